// *** common/dbt_regs.vh ***
/*
  constants for the dma bus-cycle engine: clock rate, cycle lengths,
  operation codes and command-register indices.
  assumes inclusion by bare name from the design files.
*/
`ifndef DBT_REGS_VH
`define DBT_REGS_VH

`define DBT_CLK_HZ 20000000
// standard cycle lengths in clocks
`define DBT_MEM_CLKS 3
`define DBT_IO_CLKS 4
// grant must be seen low this many clocks before mastering
`define DBT_GRANT_CLKS 2
// status drive delay in rising edges
`define DBT_RD_DELAY 2
// operation field of command register 0
`define DBT_OP_XFER 2'h0
`define DBT_OP_SEARCH 2'h1
`define DBT_OP_SIMUL 2'h2
// command register indices (low address bits)
`define DBT_REG_CTRL 3'h0
`define DBT_REG_SRCLO 3'h1
`define DBT_REG_SRCHI 3'h2
`define DBT_REG_DSTLO 3'h3
`define DBT_REG_DSTHI 3'h4
`define DBT_REG_MATCH 3'h5
`define DBT_REG_CNT 3'h6
`define DBT_NREGS 7
// control register bit positions
`define DBT_CTL_EN 0
`define DBT_CTL_OP 2:1
`define DBT_CTL_SRC_IO 3
`define DBT_CTL_DST_IO 4
`define DBT_CTL_WAITMUX 5
`define DBT_CTL_RESET 8'h00
`define DBT_CNT_RESET 8'h01

`endif

// *** hdl/dbt_slave_port.v ***
/*
  host-side register port: write strobe latching, command register
  file and delayed status read drive.
  assumes strobes synchronous to the clock and grant high while the
  host owns the bus.
*/
`include "dbt_regs.vh"
module dbt_slave_port (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // host strobes
  input wire ce_n_i,
  input wire io_request_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire [2:0] addr_i,
  input wire [7:0] data_i,
  input wire hold_grant_n_i,
  // status in
  input wire [7:0] status_i,
  // register outputs
  output wire [7:0] ctrl_o,
  output wire [15:0] src_o,
  output wire [15:0] dst_o,
  output wire [7:0] match_o,
  output wire [7:0] count_o,
  output wire ctrl_wr_o,
  output reg [7:0] rd_data_o,
  output reg rd_oe_o
);
  reg wr_lat_ff;
  reg [2:0] wa_ff;
  reg [1:0] rd_cnt_ff;
  reg [7:0] regs_ff [0:`DBT_NREGS-1];
  wire host_owns = hold_grant_n_i;
  wire wr_hit = host_owns && !ce_n_i && !io_request_n_i && !wr_n_i;
  wire rd_hit = host_owns && !ce_n_i && !io_request_n_i && !rd_n_i;
  genvar g;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_lat_ff <= 1'b0;
      wa_ff <= 3'h0;
    end else begin
      wr_lat_ff <= wr_hit;
      wa_ff <= addr_i;
    end
  end

  // data is taken one edge after the strobes were latched
  generate
    for (g = 0; g < `DBT_NREGS; g = g + 1) begin : g_reg
      always @(posedge clk_i) begin
        if (rst_i) begin
          regs_ff[g] <= (g == `DBT_REG_CNT) ? `DBT_CNT_RESET
                                             : `DBT_CTL_RESET;
        end else if (wr_lat_ff && wa_ff == g) begin
          regs_ff[g] <= data_i;
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_cnt_ff <= 2'h0;
      rd_oe_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else if (!rd_hit) begin
      rd_cnt_ff <= 2'h0;
      rd_oe_o <= 1'b0;
    end else if (rd_cnt_ff < `DBT_RD_DELAY - 1) begin
      rd_cnt_ff <= rd_cnt_ff + 2'h1;
    end else begin
      rd_oe_o <= 1'b1;
      rd_data_o <= status_i;
    end
  end

  assign ctrl_o = regs_ff[`DBT_REG_CTRL];
  assign src_o = {regs_ff[`DBT_REG_SRCHI], regs_ff[`DBT_REG_SRCLO]};
  assign dst_o = {regs_ff[`DBT_REG_DSTHI], regs_ff[`DBT_REG_DSTLO]};
  assign match_o = regs_ff[`DBT_REG_MATCH];
  assign count_o = regs_ff[`DBT_REG_CNT];
  assign ctrl_wr_o = wr_lat_ff && wa_ff == `DBT_REG_CTRL;
endmodule // dbt_slave_port

// *** hdl/dbt_hold_ctrl.v ***
/*
  bus hold request and grant qualification.
  assumes the host grants at a rising edge and resumes one clock after
  the request is withdrawn.
*/
`include "dbt_regs.vh"
module dbt_hold_ctrl (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // control
  input wire enable_i,
  input wire ready_i,
  input wire release_i,
  input wire grant_chain_in_n_i,
  input wire hold_grant_n_i,
  // outputs
  output reg hold_request_n_o,
  output wire master_o
);
  reg [1:0] gcnt_ff;
  reg ready_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_request_n_o <= 1'b1;
      gcnt_ff <= 2'h0;
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= ready_i;
      if (release_i) begin
        hold_request_n_o <= 1'b1;
      end else if (enable_i && ready_ff && hold_request_n_o &&
                   grant_chain_in_n_i) begin
        hold_request_n_o <= 1'b0;
      end
      if (hold_grant_n_i || hold_request_n_o) begin
        gcnt_ff <= 2'h0;
      end else if (gcnt_ff < `DBT_GRANT_CLKS) begin
        gcnt_ff <= gcnt_ff + 2'h1;
      end
    end
  end
  // mastering needs the grant still low, never a stale count
  assign master_o = (gcnt_ff == `DBT_GRANT_CLKS) && !hold_grant_n_i;
endmodule // dbt_hold_ctrl

// *** hdl/dbt_engine.v ***
/*
  byte-mode dma bus-cycle engine: host register port, bus hold and
  master read/write cycle sequencing with wait states.
  assumes all pins synchronous to the 20 MHz clock and an external
  resolver that turns data/address/control enables into pin levels.
*/
`include "dbt_regs.vh"
module dbt_engine (
  // clock and reset
  input wire CLOCK_I,
  input wire RST_I,
  // host slave strobes
  input wire CE_N_I,
  input wire IO_REQUEST_N_I,
  input wire RD_N_I,
  input wire WR_N_I,
  // wait input when multiplexed on the select pin
  input wire WAIT_N_I,
  // bus hold
  input wire READY_I,
  input wire HOLD_GRANT_N_I,
  input wire GRANT_CHAIN_IN_N_I,
  output wire HOLD_REQUEST_N_O,
  // address bus
  input wire [15:0] ADDR_I,
  output reg [15:0] ADDR_O,
  output wire ADDR_OE_O,
  // data bus
  input wire [7:0] DATA_I,
  output wire [7:0] DATA_O,
  output wire DATA_OE_O,
  // bus control
  output wire MEMORY_REQUEST_N_O,
  output wire IO_REQUEST_N_O,
  output wire RD_N_O,
  output wire WR_N_O,
  output wire CTRL_OE_O,
  // status
  output wire MATCH_O,
  output wire DONE_O
);
  localparam S_IDLE = 7'h01;
  localparam S_T1 = 7'h02;
  localparam S_T2 = 7'h04;
  localparam S_TA = 7'h08;
  localparam S_TW = 7'h10;
  localparam S_T3 = 7'h20;
  localparam S_GAP = 7'h40;

  wire [7:0] ctrl;
  wire [15:0] src;
  wire [15:0] dst;
  wire [7:0] match_byte;
  wire [7:0] count;
  wire ctrl_wr;
  wire [7:0] rd_data;
  wire rd_oe;
  wire master;
  reg [6:0] st_ff;
  reg [6:0] nxt_st;
  reg wphase_ff;
  reg [15:0] sa_ff;
  reg [15:0] da_ff;
  reg [7:0] left_ff;
  reg [7:0] dlat_ff;
  reg dvalid_ff;
  reg match_ff;
  reg done_ff;
  reg en_ff;
  reg memory_request_n_ff;
  reg io_request_n_ff;
  reg rd_ff;
  reg wr_ff;
  // byte taken on the T3 fall and the wait level taken on a fall
  reg [7:0] rd_cap_ff;
  reg wait_low_ff;
  wire [1:0] op = ctrl[`DBT_CTL_OP];
  wire src_io = ctrl[`DBT_CTL_SRC_IO];
  wire dst_io = ctrl[`DBT_CTL_DST_IO];
  wire cyc_io = wphase_ff ? dst_io : src_io;
  wire read_only = (op != `DBT_OP_XFER);
  wire last_phase = wphase_ff || read_only;
  // stall allowed only on memory read or io write
  wire wait_pt = ctrl[`DBT_CTL_WAITMUX] &&
                 (cyc_io ? wphase_ff : !wphase_ff);
  wire stall = wait_low_ff;
  // request drops on the edge entering the final T3; the grant stays
  // low through T3, so the cycle ends before the host takes over
  wire bus_release = (nxt_st == S_T3) && last_phase;
  wire [7:0] status = {5'h00, dvalid_ff, match_ff, done_ff};

  dbt_slave_port u_slave (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_n_i(CE_N_I),
    .io_request_n_i(IO_REQUEST_N_I),
    .rd_n_i(RD_N_I),
    .wr_n_i(WR_N_I),
    .addr_i(ADDR_I[2:0]),
    .data_i(DATA_I),
    .hold_grant_n_i(HOLD_GRANT_N_I),
    .status_i(status),
    .ctrl_o(ctrl),
    .src_o(src),
    .dst_o(dst),
    .match_o(match_byte),
    .count_o(count),
    .ctrl_wr_o(ctrl_wr),
    .rd_data_o(rd_data),
    .rd_oe_o(rd_oe)
  );

  dbt_hold_ctrl u_hold (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .enable_i(en_ff),
    .ready_i(READY_I),
    .release_i(bus_release),
    .grant_chain_in_n_i(GRANT_CHAIN_IN_N_I),
    .hold_grant_n_i(HOLD_GRANT_N_I),
    .hold_request_n_o(HOLD_REQUEST_N_O),
    .master_o(master)
  );

  // sequencing: T1, T2, auto stall (io), stall while wait low, T3
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: begin
        if (master && en_ff) begin
          nxt_st = S_T1;
        end
      end
      S_T1: begin
        nxt_st = S_T2;
      end
      S_T2: begin
        if (cyc_io) begin
          nxt_st = S_TA;
        end else if (stall) begin
          nxt_st = S_TW;
        end else begin
          nxt_st = S_T3;
        end
      end
      S_TA: begin
        nxt_st = stall ? S_TW : S_T3;
      end
      S_TW: begin
        nxt_st = stall ? S_TW : S_T3;
      end
      S_T3: begin
        if (last_phase) begin
          nxt_st = S_GAP;
        end else begin
          nxt_st = S_T1;
        end
      end
      S_GAP: begin
        nxt_st = S_IDLE;
      end
      default: begin
        nxt_st = S_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      st_ff <= S_IDLE;
      wphase_ff <= 1'b0;
      sa_ff <= 16'h0000;
      da_ff <= 16'h0000;
      left_ff <= 8'h00;
      dlat_ff <= 8'h00;
      dvalid_ff <= 1'b0;
      match_ff <= 1'b0;
      done_ff <= 1'b0;
      en_ff <= 1'b0;
      ADDR_O <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      if (ctrl_wr) begin
        // a fresh control write reloads the transfer
        en_ff <= DATA_I[`DBT_CTL_EN];
        sa_ff <= src;
        da_ff <= dst;
        left_ff <= count;
        done_ff <= 1'b0;
        match_ff <= 1'b0;
      end
      if (nxt_st == S_T1) begin
        ADDR_O <= (st_ff == S_T3) ? da_ff : sa_ff;
      end
      if (st_ff == S_T3) begin
        if (!wphase_ff) begin
          dlat_ff <= rd_cap_ff;
          dvalid_ff <= 1'b1;
          if (rd_cap_ff == match_byte) begin
            match_ff <= 1'b1;
          end
        end
        wphase_ff <= !last_phase;
        if (last_phase) begin
          sa_ff <= sa_ff + 16'h0001;
          da_ff <= da_ff + 16'h0001;
          left_ff <= left_ff - 8'h01;
          if (left_ff == 8'h01) begin
            en_ff <= 1'b0;
            done_ff <= 1'b1;
          end
        end
      end
    end
  end

  // strobe edges: mid-T1 memory, T2 rise io write/mem write, mid-T2 io read
  always @(negedge CLOCK_I) begin
    if (RST_I) begin
      memory_request_n_ff <= 1'b0;
      io_request_n_ff <= 1'b0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      if (st_ff[0] || st_ff[6] || st_ff[5]) begin
        memory_request_n_ff <= 1'b0;
        io_request_n_ff <= 1'b0;
        rd_ff <= 1'b0;
      end else if (st_ff[1] && !cyc_io) begin
        memory_request_n_ff <= 1'b1;
        rd_ff <= !wphase_ff;
      end else if (st_ff[2] && cyc_io && !wphase_ff) begin
        io_request_n_ff <= 1'b1;
        rd_ff <= 1'b1;
      end else if (st_ff[2] && cyc_io) begin
        io_request_n_ff <= 1'b1;
      end
      wr_ff <= wphase_ff && (st_ff[2] || st_ff[3] || st_ff[4]);
    end
  end

  // the source lets go of the bus as the read strobe rises, so the byte
  // is taken on the T3 fall while the strobe is still low
  always @(negedge CLOCK_I) begin
    if (RST_I) begin
      rd_cap_ff <= 8'h00;
    end else if (st_ff[5] && !wphase_ff) begin
      rd_cap_ff <= DATA_I;
    end
  end

  // wait is looked at on the falling edge of T2 or of a stall clock; the
  // next rising edge then decides whether one more stall clock follows
  always @(negedge CLOCK_I) begin
    if (RST_I) begin
      wait_low_ff <= 1'b0;
    end else begin
      wait_low_ff <= wait_pt && !WAIT_N_I;
    end
  end

  // io write strobes start at the T2 rise, half a clock before the latch
  wire io_wr_early = wphase_ff && cyc_io && st_ff[2];
  wire wr_early = wphase_ff && st_ff[2];
  wire in_cycle = master && !st_ff[0];
  // simultaneous mode drives only the read side; outside logic does rest
  assign MEMORY_REQUEST_N_O = !memory_request_n_ff;
  assign IO_REQUEST_N_O = !(io_request_n_ff || io_wr_early);
  assign RD_N_O = !rd_ff;
  assign WR_N_O = !(wr_ff || wr_early);
  assign CTRL_OE_O = in_cycle;
  assign ADDR_OE_O = in_cycle;
  // latched byte driven after read strobe rises, through the write
  assign DATA_OE_O = rd_oe || (in_cycle && wphase_ff);
  assign DATA_O = rd_oe ? rd_data : dlat_ff;
  assign MATCH_O = match_ff;
  assign DONE_O = done_ff;
endmodule // dbt_engine

// *** testbench/dbt_engine_properties.sv ***
/* pin checker for the dma bus-cycle engine.
   assumes a bind onto dbt_engine and a single clock domain. */
module dbt_engine_props (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // host side
  input wire logic CE_N_I,
  input wire logic IO_REQUEST_N_I,
  input wire logic RD_N_I,
  input wire logic READY_I,
  input wire logic HOLD_GRANT_N_I,
  // engine outputs
  input wire logic HOLD_REQUEST_N_O,
  input wire logic ADDR_OE_O,
  input wire logic DATA_OE_O,
  input wire logic MEMORY_REQUEST_N_O,
  input wire logic IO_REQUEST_N_O,
  input wire logic RD_N_O,
  input wire logic WR_N_O,
  input wire logic CTRL_OE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  wire stat_rd = !CE_N_I && !IO_REQUEST_N_I && !RD_N_I && HOLD_GRANT_N_I;
  sequence stat_held; stat_rd [*3]; endsequence
  sequence rd_start; $fell(RD_N_O); endsequence
  sequence grant_seen; $fell(HOLD_GRANT_N_I); endsequence
  master_grant_a: assert property (
    (ADDR_OE_O || CTRL_OE_O) |-> !HOLD_GRANT_N_I) else $error("no grant");
  stat_drive_a: assert property (
    stat_held |-> DATA_OE_O) else $error("status not driven");
  read_float_a: assert property (
    DATA_OE_O && !HOLD_GRANT_N_I |-> RD_N_O) else $error("drive in read");
  req_ready_a: assert property (
    $fell(HOLD_REQUEST_N_O) |-> $past(READY_I) && $past(HOLD_GRANT_N_I))
    else $error("request without ready");
  grant_wait_a: assert property (
    grant_seen |-> !ADDR_OE_O ##1 !ADDR_OE_O ##[1:3] ADDR_OE_O)
    else $error("grant wait wrong");
  read_len_a: assert property (
    rd_start |-> ##1 !RD_N_O ##[1:2] RD_N_O) else $error("read length");
  release_early_a: assert property (
    $rose(HOLD_REQUEST_N_O) |-> CTRL_OE_O) else $error("late release");
  write_data_a: assert property (
    !WR_N_O && CTRL_OE_O |-> DATA_OE_O) else $error("write without data");
  one_space_a: assert property (
    MEMORY_REQUEST_N_O || IO_REQUEST_N_O) else $error("both spaces");
endmodule // dbt_engine_props

bind dbt_engine dbt_engine_props u_props (.CLOCK_I, .RST_I, .CE_N_I,
  .IO_REQUEST_N_I, .RD_N_I, .READY_I, .HOLD_GRANT_N_I, .HOLD_REQUEST_N_O,
  .ADDR_OE_O, .DATA_OE_O, .MEMORY_REQUEST_N_O, .IO_REQUEST_N_O, .RD_N_O,
  .WR_N_O, .CTRL_OE_O);

// *** testbench/dbt_host_model.sv ***
/* host processor model: grants the bus and serves read data.
   assumes the engine clock; slow mode stretches machine cycles. */
module dbt_host_model #(
  parameter [7:0] RD_BYTE = 8'h5C
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // four-clock machine cycles when high
  input wire logic slow_i,
  // engine pins
  input wire logic hold_request_n_i,
  input wire logic rd_n_i,
  output logic hold_grant_n_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cyc_ff;
  logic [7:0] idle_ff;
  // an undriven bus never repeats the last byte
  assign data_o = rd_n_i ? idle_ff : RD_BYTE;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_grant_n_o <= 1'b1;
      cyc_ff <= 2'h0;
      idle_ff <= 8'hA3;
    end else begin
      cyc_ff <= cyc_ff + 2'h1;
      idle_ff <= idle_ff + 8'h35;
      if (hold_request_n_i)
        hold_grant_n_o <= 1'b1;
      else if (!slow_i || cyc_ff == 2'h3)
        hold_grant_n_o <= 1'b0;
    end
  end
endmodule // dbt_host_model

// *** testbench/dbt_engine_test.sv ***
/* self-checking bench for the dma bus-cycle engine.
   assumes the host model stands on the far side of the bus. */
`define CHK(n, e, g) begin total_checks++; \
  if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module dbt_engine_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [7:0] RD_BYTE = 8'h5C;
  logic CLOCK_I, RST_I, CE_N_I, IO_REQUEST_N_I, RD_N_I, WR_N_I, WAIT_N_I;
  logic READY_I, HOLD_GRANT_N_I, GRANT_CHAIN_IN_N_I, HOLD_REQUEST_N_O;
  logic [15:0] ADDR_I, ADDR_O;
  logic [7:0] DATA_I, DATA_O, tb_data, mdl_data, st;
  logic ADDR_OE_O, DATA_OE_O, MEMORY_REQUEST_N_O, IO_REQUEST_N_O, RD_N_O;
  logic WR_N_O, CTRL_OE_O, MATCH_O, DONE_O, slow;
  int failures, total_checks;
  // single device, so the chain input follows the grant
  assign GRANT_CHAIN_IN_N_I = HOLD_GRANT_N_I;
  assign DATA_I = DATA_OE_O ? DATA_O : (HOLD_GRANT_N_I ? tb_data : mdl_data);
  dbt_engine dut (.CLOCK_I, .RST_I, .CE_N_I, .IO_REQUEST_N_I, .RD_N_I,
    .WR_N_I, .WAIT_N_I, .READY_I, .HOLD_GRANT_N_I, .GRANT_CHAIN_IN_N_I,
    .HOLD_REQUEST_N_O, .ADDR_I, .ADDR_O, .ADDR_OE_O, .DATA_I, .DATA_O,
    .DATA_OE_O, .MEMORY_REQUEST_N_O, .IO_REQUEST_N_O, .RD_N_O, .WR_N_O,
    .CTRL_OE_O, .MATCH_O, .DONE_O);
  dbt_host_model #(.RD_BYTE(RD_BYTE)) host (.clk_i(CLOCK_I), .rst_i(RST_I),
    .slow_i(slow), .hold_request_n_i(HOLD_REQUEST_N_O), .rd_n_i(RD_N_O),
    .hold_grant_n_o(HOLD_GRANT_N_I), .data_o(mdl_data));
  initial begin
    CLOCK_I = 1'b0;
    forever #25 CLOCK_I = ~CLOCK_I;
  end
  task step(input int n);
    repeat (n) @(posedge CLOCK_I);
    #1;
  endtask
  task finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // data stays one edge past the strobes, as the capture needs
  task wr_reg(input [2:0] a, input [7:0] d);
    ADDR_I = {13'h0000, a};
    tb_data = d;
    {CE_N_I, IO_REQUEST_N_I, WR_N_I} = 3'h0;
    step(1);
    {CE_N_I, IO_REQUEST_N_I, WR_N_I} = 3'h7;
    step(1);
  endtask
  task rd_stat;
    {CE_N_I, IO_REQUEST_N_I, RD_N_I} = 3'h0;
    step(3);
    `CHK("stat oe", 1'b1, DATA_OE_O)
    st = DATA_O;
    {CE_N_I, IO_REQUEST_N_I, RD_N_I} = 3'h7;
    step(2);
    `CHK("stat off", 1'b0, DATA_OE_O)
  endtask
  // one byte: program, raise ready, watch the master cycles
  task xfer(input [7:0] ctl, input [7:0] mt, input bit w, input bit wx);
    logic [15:0] ra, wa;
    logic [7:0] wd;
    logic rm, wm, ri, wi;
    bit ws;
    int nrd;
    RST_I = 1'b1;
    step(2);
    RST_I = 1'b0;
    `CHK("idle req", 1'b1, HOLD_REQUEST_N_O)
    `CHK("idle oe", 1'b0, ADDR_OE_O | CTRL_OE_O | DATA_OE_O)
    wr_reg(3'h1, 8'h34);
    wr_reg(3'h2, 8'h12);
    wr_reg(3'h3, 8'h78);
    wr_reg(3'h4, 8'h56);
    wr_reg(3'h5, mt);
    wr_reg(3'h6, 8'h01);
    wr_reg(3'h0, ctl);
    READY_I = 1'b1;
    nrd = 0;
    ws = 0;
    for (int i = 0; i < 80; i++) begin
      step(1);
      if (!RD_N_O && nrd == 0) begin
        rm = !MEMORY_REQUEST_N_O;
        ri = !IO_REQUEST_N_O;
        ra = ADDR_O;
      end
      if (!RD_N_O)
        nrd++;
      if (!WR_N_O && !ws) begin
        ws = 1;
        wm = !MEMORY_REQUEST_N_O;
        wi = !IO_REQUEST_N_O;
        wa = ADDR_O;
        wd = DATA_O;
      end
      WAIT_N_I = !(w && nrd == 1);
    end
    READY_I = 1'b0;
    `CHK("read len", 2 + w, nrd)
    `CHK("read space", !ctl[3], rm)
    `CHK("read io", ctl[3], ri)
    `CHK("read addr", 16'h1234, ra)
    `CHK("write seen", wx, ws)
    if (wx) begin
      `CHK("write space", !ctl[4], wm)
      `CHK("write io", ctl[4], wi)
      `CHK("write addr", 16'h5678, wa)
      `CHK("write data", RD_BYTE, wd)
    end
    if (ctl[2:1] == 2'h1)
      `CHK("match", mt == RD_BYTE, MATCH_O)
    `CHK("done", 1'b1, DONE_O)
    `CHK("req free", 1'b1, HOLD_REQUEST_N_O)
  endtask
  initial begin
    {RST_I, CE_N_I, IO_REQUEST_N_I, RD_N_I, WR_N_I, WAIT_N_I} = 6'h3F;
    READY_I = 1'b0;
    ADDR_I = 16'h0000;
    tb_data = 8'h00;
    slow = 1'b0;
    failures = 0;
    total_checks = 0;
    xfer(8'h01, 8'h00, 0, 1);
    xfer(8'h11, 8'h00, 0, 1);
    xfer(8'h09, 8'h00, 0, 1);
    xfer(8'h19, 8'h00, 0, 1);
    xfer(8'h03, RD_BYTE, 0, 0);
    rd_stat;
    `CHK("stat bits", 3'h7, st[2:0])
    xfer(8'h03, 8'h11, 0, 0);
    xfer(8'h05, 8'h00, 0, 0);
    xfer(8'h0D, 8'h00, 0, 0);
    xfer(8'h21, 8'h00, 1, 1);
    slow = 1'b1;
    xfer(8'h11, 8'h00, 0, 1);
    finish_test;
  end
  // about three times the expected run length
  initial begin
    #(50 * 3000);
    failures++;
    finish_test;
  end
endmodule // dbt_engine_test
